// ==== hw/zsp_sram_port.sv ====
// memory-side end of the pipelined zero-turnaround sram bus
// assumes: all bus inputs synchronous to clk; dq resolved by zsp_if

`timescale 1ns/1ns

module zsp_sram_port #(
  parameter int ADDR_W = zsp_pkg::ADDR_W_DEF
) (
  input  wire logic clk,   // rising-edge clock
  input  wire logic rst_b, // synchronous reset, active low
  zsp_if.mem        bus    // sram bus, memory side
);
  import zsp_pkg::*;

  if (DATA_W != LANES * LANE_W || ADDR_W < STEP_W)
  begin : g_bad_shape
    $error("zsp_sram_port: word or address shape not supported");
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [STEP_W-1:0] burst_low(
    input logic [STEP_W-1:0] base,
    input logic [STEP_W-1:0] step,
    input logic              interleaved
  );
    burst_low = interleaved ? (base ^ step) : (base + step);
  endfunction : burst_low

  function automatic logic [DATA_W-1:0] lane_merge(
    input logic [DATA_W-1:0] old_word,
    input logic [DATA_W-1:0] new_word,
    input logic [LANES-1:0]  lane_en
  );
    lane_merge = old_word;
    for (int i = 0; i < LANES; i++)
    begin
      if (lane_en[i])
      begin
        lane_merge[i*LANE_W +: LANE_W] = new_word[i*LANE_W +: LANE_W];
      end
    end
  endfunction : lane_merge

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [DATA_W-1:0] mem_reg [1 << ADDR_W];
  logic [ADDR_W-1:0] base_reg;
  logic [STEP_W-1:0] step_reg;
  logic              burst_reg;
  logic              burst_read_reg;
  logic              s1_valid_reg;
  logic              s1_write_reg;
  logic [ADDR_W-1:0] s1_addr_reg;
  logic [LANES-1:0]  s1_lanes_reg;
  logic              s2_valid_reg;
  logic              s2_write_reg;
  logic [ADDR_W-1:0] s2_addr_reg;
  logic [LANES-1:0]  s2_lanes_reg;
  logic [DATA_W-1:0] dout_reg;
  logic              drive_reg;

  logic              live;
  logic              selected;
  logic              load;
  logic [STEP_W-1:0] step_next;
  logic              cmd_valid;
  logic              cmd_write;
  logic [ADDR_W-1:0] cmd_addr;
  logic [LANES-1:0]  cmd_lanes;
  logic              s2_wr;
  logic [DATA_W-1:0] read_word;

  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------
  // sleep is modelled as a held clock: nothing moves, array retained
  assign live = !bus.cycle_hold_n && !bus.sleep_request;

  assign selected = !bus.select_low_a_n && !bus.select_low_b_n
                    && bus.select_high;
  assign load      = !bus.advance_or_load;
  assign step_next = step_reg + STEP_W'(1);

  always_comb
  begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr  = base_reg;
    cmd_lanes = LANES_NONE;
    if (load)
    begin
      if (selected)
      begin
        cmd_valid = 1'b1;
        cmd_write = !bus.read_not_write;
        cmd_addr  = bus.addr;
      end
    end
    else if (burst_reg)
    begin
      cmd_valid = 1'b1;
      cmd_write = !burst_read_reg;
      cmd_addr  = {base_reg[ADDR_W-1:STEP_W],
                   burst_low(base_reg[STEP_W-1:0], step_next,
                             bus.burst_order_sel)};
    end
    // lanes only count on a write cycle with read not selected
    if (cmd_write && !bus.read_not_write)
    begin
      cmd_lanes = ~bus.byte_lane_write_n;
    end
  end

  // ------------------------------------------------------------
  // burst tracking
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      burst_reg      <= 1'b0;
      burst_read_reg <= 1'b1;
      step_reg       <= '0;
      base_reg       <= '0;
    end
    else if (live)
    begin
      if (load && selected)
      begin
        burst_reg      <= 1'b1;
        burst_read_reg <= bus.read_not_write;
        base_reg       <= bus.addr;
        step_reg       <= '0;
      end
      else if (load)
      begin
        burst_reg <= 1'b0;
      end
      else if (burst_reg)
      begin
        step_reg <= step_next;
      end
    end
  end

  // ------------------------------------------------------------
  // two-stage command pipeline
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      s1_valid_reg <= 1'b0;
      s1_write_reg <= 1'b0;
      s1_addr_reg  <= '0;
      s1_lanes_reg <= LANES_NONE;
      s2_valid_reg <= 1'b0;
      s2_write_reg <= 1'b0;
      s2_addr_reg  <= '0;
      s2_lanes_reg <= LANES_NONE;
    end
    else if (live)
    begin
      s1_valid_reg <= cmd_valid;
      s1_write_reg <= cmd_write;
      s1_addr_reg  <= cmd_addr;
      s1_lanes_reg <= cmd_lanes;
      s2_valid_reg <= s1_valid_reg;
      s2_write_reg <= s1_write_reg;
      s2_addr_reg  <= s1_addr_reg;
      s2_lanes_reg <= s1_lanes_reg;
    end
  end

  // ------------------------------------------------------------
  // array write, sampled from the bus on the second edge
  // ------------------------------------------------------------
  assign s2_wr = live && s2_valid_reg && s2_write_reg;

  always_ff @(posedge clk)
  begin
    if (s2_wr)
    begin
      mem_reg[s2_addr_reg] <= lane_merge(mem_reg[s2_addr_reg], bus.dq,
                                         s2_lanes_reg);
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  // a write landing on the same edge is forwarded, so a read right
  // behind a write to the same word never returns stale lanes
  always_comb
  begin
    read_word = mem_reg[s1_addr_reg];
    if (s2_valid_reg && s2_write_reg && s2_addr_reg == s1_addr_reg)
    begin
      read_word = lane_merge(read_word, bus.dq, s2_lanes_reg);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      dout_reg  <= DATA_RST;
      drive_reg <= 1'b0;
    end
    else if (live)
    begin
      if (s1_valid_reg && !s1_write_reg)
      begin
        dout_reg <= read_word;
      end
      drive_reg <= s1_valid_reg && !s1_write_reg;
    end
  end

  // ------------------------------------------------------------
  // pins
  // ------------------------------------------------------------
  // output enable acts without the clock, hence the gate after the flop
  assign bus.dev_dq_out = dout_reg;
  assign bus.dev_dq_oe  = drive_reg && !bus.output_en_n
                          && !bus.sleep_request;

endmodule : zsp_sram_port

// ==== hw/zsp_pkg.sv ====
// shared constants for the pipelined zero-turnaround sram port
// assumes: both ends and the interface import this package

package zsp_pkg;

  // ------------------------------------------------------------
  // word layout
  // ------------------------------------------------------------
  localparam int DATA_W     = 36;
  localparam int LANES      = 4;
  localparam int LANE_W     = 9;
  localparam int ADDR_W_DEF = 18;

  // ------------------------------------------------------------
  // burst and pipeline
  // ------------------------------------------------------------
  localparam int BURST_LEN  = 4;
  localparam int STEP_W     = 2;
  localparam int FIFO_DEPTH = 16;

  // ------------------------------------------------------------
  // values after reset
  // ------------------------------------------------------------
  localparam logic [DATA_W-1:0] DATA_RST   = 36'h0;
  localparam logic [LANES-1:0]  LANES_NONE = 4'h0;
  localparam logic [LANES-1:0]  LANES_OFF_N = 4'hf;

endpackage : zsp_pkg

// ==== hw/zsp_if.sv ====
// shared sram bus between the memory controller and the sram port
// assumes: the bench instantiates one per bus and hands the modports out

`timescale 1ns/1ns

interface zsp_if #(
  parameter int ADDR_W = zsp_pkg::ADDR_W_DEF
);
  import zsp_pkg::*;

  logic [ADDR_W-1:0] addr;
  logic              read_not_write;
  logic              advance_or_load;
  logic [LANES-1:0]  byte_lane_write_n;
  logic              select_low_a_n;
  logic              select_low_b_n;
  logic              select_high;
  logic              cycle_hold_n;
  logic              burst_order_sel;
  logic              output_en_n;
  logic              sleep_request;
  logic [DATA_W-1:0] ctl_dq_out;
  logic              ctl_dq_oe;
  logic [DATA_W-1:0] dev_dq_out;
  logic              dev_dq_oe;
  logic [DATA_W-1:0] dq;

  // ------------------------------------------------------------
  // wire level: an undriven bus reads as zero
  // ------------------------------------------------------------
  assign dq = dev_dq_oe ? dev_dq_out : (ctl_dq_oe ? ctl_dq_out : '0);

  modport mem (
    input  addr, read_not_write, advance_or_load, byte_lane_write_n,
    input  select_low_a_n, select_low_b_n, select_high, cycle_hold_n,
    input  burst_order_sel, output_en_n, sleep_request, dq,
    output dev_dq_out, dev_dq_oe
  );

  modport ctl (
    output addr, read_not_write, advance_or_load, byte_lane_write_n,
    output select_low_a_n, select_low_b_n, select_high, cycle_hold_n,
    output burst_order_sel, output_en_n, sleep_request,
    output ctl_dq_out, ctl_dq_oe,
    input  dq
  );

endinterface : zsp_if

// ==== hw/zsp_fifo.sv ====
// small synchronous fifo with valid/ready on both sides
// assumes: one clock, synchronous active-low reset, DEPTH a power of two

`timescale 1ns/1ns

module zsp_fifo #(
  parameter int WIDTH = zsp_pkg::DATA_W,
  parameter int DEPTH = zsp_pkg::FIFO_DEPTH
) (
  input  wire logic                     clk,       // clock
  input  wire logic                     rst_b,     // sync reset, low
  input  wire logic                     in_valid,  // write side valid
  output logic                          in_ready,  // not full
  input  wire logic [WIDTH-1:0]         in_data,   // write data
  output logic                          out_valid, // not empty
  input  wire logic                     out_ready, // read side ready
  output logic [WIDTH-1:0]              out_data,  // head word
  output logic [$clog2(DEPTH):0]        level      // words held
);
  import zsp_pkg::*;

  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PW) != DEPTH)
  begin : g_bad_depth
    $error("zsp_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_reg;
  logic [PW-1:0]    rd_reg;
  logic [PW:0]      cnt_reg;
  logic             push;
  logic             pop;

  assign in_ready  = cnt_reg != (PW+1)'(DEPTH);
  assign out_valid = cnt_reg != '0;
  assign out_data  = mem_reg[rd_reg];
  assign level     = cnt_reg;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_reg <= wr_reg + PW'(1);
      end
      if (pop)
      begin
        rd_reg <= rd_reg + PW'(1);
      end
      cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule : zsp_fifo

// ==== hw/zsp_sram_ctl.sv ====
// controller end of the sram bus: one load cycle per user command
// assumes: the port end samples the same clk; reads return via fifo

`timescale 1ns/1ns

module zsp_sram_ctl #(
  parameter int   ADDR_W      = zsp_pkg::ADDR_W_DEF,
  parameter int   DEPTH       = zsp_pkg::FIFO_DEPTH,
  parameter logic INTERLEAVED = 1'b0
) (
  input  wire logic                      clk,       // clock
  input  wire logic                      rst_b,     // sync reset, low
  input  wire logic                      cmd_valid, // command offered
  output logic                           cmd_ready, // command taken
  input  wire logic                      cmd_write, // 1 write, 0 read
  input  wire logic [ADDR_W-1:0]         cmd_addr,  // word address
  input  wire logic [zsp_pkg::LANES-1:0] cmd_lanes, // lanes to write
  input  wire logic [zsp_pkg::DATA_W-1:0] cmd_wdata, // write data
  output logic                           rd_valid,  // read word ready
  input  wire logic                      rd_ready,  // read word taken
  output logic [zsp_pkg::DATA_W-1:0]     rd_data,   // read word
  zsp_if.ctl                             bus        // sram bus
);
  import zsp_pkg::*;

  localparam int CW = $clog2(DEPTH) + 3;

  if (DEPTH < 8)
  begin : g_bad_depth
    $error("zsp_sram_ctl: DEPTH must cover the read pipeline");
  end

  logic              take;
  logic              p0_valid_reg;
  logic              p0_write_reg;
  logic [DATA_W-1:0] p0_data_reg;
  logic              q1_valid_reg;
  logic              q1_write_reg;
  logic [DATA_W-1:0] q1_data_reg;
  logic              q2_read_reg;
  logic              ready_reg;
  logic [DATA_W-1:0] dq_out_reg;
  logic              dq_oe_reg;
  logic              fifo_in_ready;
  logic [$clog2(DEPTH):0] fifo_level;
  logic [CW-1:0]     need;

  assign take      = cmd_valid && ready_reg;
  assign cmd_ready = ready_reg;

  // ------------------------------------------------------------
  // pin drive: idle cycles are deselects so no burst advances
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      bus.addr              <= '0;
      bus.read_not_write    <= 1'b1;
      bus.advance_or_load   <= 1'b0;
      bus.byte_lane_write_n <= LANES_OFF_N;
      bus.select_low_a_n    <= 1'b1;
      bus.select_low_b_n    <= 1'b0;
      bus.select_high       <= 1'b1;
      bus.cycle_hold_n      <= 1'b0;
      bus.burst_order_sel   <= INTERLEAVED;
      bus.output_en_n       <= 1'b0;
      bus.sleep_request     <= 1'b0;
    end
    else
    begin
      bus.select_low_a_n  <= !take;
      bus.advance_or_load <= 1'b0;
      if (take)
      begin
        bus.addr              <= cmd_addr;
        bus.read_not_write    <= !cmd_write;
        bus.byte_lane_write_n <= cmd_write ? ~cmd_lanes
                                           : LANES_OFF_N;
      end
    end
  end

  // ------------------------------------------------------------
  // data pipeline: data cycle follows the sampled command by two
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      p0_valid_reg <= 1'b0;
      p0_write_reg <= 1'b0;
      p0_data_reg  <= DATA_RST;
      q1_valid_reg <= 1'b0;
      q1_write_reg <= 1'b0;
      q1_data_reg  <= DATA_RST;
      q2_read_reg  <= 1'b0;
      dq_out_reg   <= DATA_RST;
      dq_oe_reg    <= 1'b0;
    end
    else
    begin
      p0_valid_reg <= take;
      p0_write_reg <= cmd_write;
      p0_data_reg  <= cmd_wdata;
      q1_valid_reg <= p0_valid_reg;
      q1_write_reg <= p0_write_reg;
      q1_data_reg  <= p0_data_reg;
      q2_read_reg  <= q1_valid_reg && !q1_write_reg;
      dq_out_reg   <= q1_data_reg;
      dq_oe_reg    <= q1_valid_reg && q1_write_reg;
    end
  end

  assign bus.ctl_dq_out = dq_out_reg;
  assign bus.ctl_dq_oe  = dq_oe_reg;

  // ------------------------------------------------------------
  // credit: never issue a read the fifo could not absorb
  // ------------------------------------------------------------
  // the extra slot covers a read taken on the edge after next, since ready is registered
  assign need = CW'(fifo_level)
              + CW'(p0_valid_reg && !p0_write_reg)
              + CW'(q1_valid_reg && !q1_write_reg)
              + CW'(q2_read_reg)
              + CW'(take && !cmd_write)
              + CW'(1);

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ready_reg <= 1'b0;
    end
    else
    begin
      ready_reg <= fifo_in_ready && (need <= CW'(DEPTH));
    end
  end

  zsp_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH)
  ) u_rd_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (q2_read_reg),
    .in_ready  (fifo_in_ready),
    .in_data   (bus.dq),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data),
    .level     (fifo_level)
  );

endmodule : zsp_sram_ctl

// ==== verif/zsp_sram_checker.sv ====
// bus assertions between the controller end and the sram port end
// assumes: instantiated beside the zsp_if joining the two ends

`timescale 1ns/1ns

module zsp_sram_checker (
  input wire logic clk,             // clock
  input wire logic rst_b,           // sync reset, low
  input wire logic read_not_write,  // 1 read
  input wire logic advance_or_load, // 0 load
  input wire logic select_low_a_n,  // select, low
  input wire logic select_low_b_n,  // select, low
  input wire logic select_high,     // select, high
  input wire logic cycle_hold_n,    // 1 suspends the edge
  input wire logic burst_order_sel, // burst order
  input wire logic sleep_request,   // sleep
  input wire logic ctl_dq_oe,       // controller drives dq
  input wire logic dev_dq_oe        // port drives dq
);
  logic live;
  logic sel;
  logic ld_rd;
  logic ld_wr;
  logic dsel;

  assign live  = !cycle_hold_n && !sleep_request;
  assign sel   = !select_low_a_n && !select_low_b_n && select_high;
  assign ld_rd = live && !advance_or_load && sel && read_not_write;
  assign ld_wr = live && !advance_or_load && sel && !read_not_write;
  assign dsel  = live && !advance_or_load && !sel;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // ------------------------------------------------------------
  // data turn two cycles after each read or write load
  // ------------------------------------------------------------
  sequence s_load_read;
    ld_rd;
  endsequence
  sequence s_load_write;
    ld_wr;
  endsequence
  sequence s_dev_turn;
    ##2 (dev_dq_oe && !ctl_dq_oe);
  endsequence
  sequence s_ctl_turn;
    ##2 (ctl_dq_oe && !dev_dq_oe);
  endsequence

  a_read_two_later:
    assert property (s_load_read |-> s_dev_turn)
    else $error("read data not driven two cycles after load");
  a_write_two_later:
    assert property (s_load_write |-> s_ctl_turn)
    else $error("write data not on the bus two cycles after load");
  a_deselect_release:
    assert property (dsel |-> ##2 !dev_dq_oe)
    else $error("port still drives two cycles after deselect");
  a_port_drive_cause:
    assert property (dev_dq_oe |-> $past(ld_rd, 2))
    else $error("port drives without a read load two cycles before");
  a_ctl_drive_cause:
    assert property (ctl_dq_oe |-> $past(ld_wr, 2))
    else $error("controller drives without a write load");
  a_no_clash:
    assert property (!(dev_dq_oe && ctl_dq_oe))
    else $error("both ends drive the data bus");
  a_hold_kept_low:
    assert property (cycle_hold_n == 1'b0)
    else $error("controller suspended an edge");
  a_order_fixed:
    assert property ($stable(burst_order_sel))
    else $error("burst order changed in operation");

endmodule : zsp_sram_checker

// ==== verif/pipelined_zero_turnaround_sram_port_tb_top.sv ====
// top bench: controller and port joined, plus a second port driven here
// assumes: zsp_pkg, zsp_if, zsp_fifo, both ends and the checker compiled

`timescale 1ns/1ns

module pipelined_zero_turnaround_sram_port_tb_top;
  import zsp_pkg::*;
  localparam int AW    = 6;
  localparam int LIMIT = 20000;
  localparam int DEPTH_FILL = FIFO_DEPTH;
  typedef logic [DATA_W-1:0] zsp_word_type;

  logic             clk = 1'b0;
  logic             rst_b = 1'b0;
  logic             cmd_valid = 1'b0;
  logic             cmd_write = 1'b0;
  logic             rd_ready = 1'b0;
  logic             stall = 1'b1;
  logic [AW-1:0]    cmd_addr = '0;
  logic [LANES-1:0] cmd_lanes = '0;
  zsp_word_type     cmd_wdata = '0;
  logic             cmd_ready;
  logic             rd_valid;
  zsp_word_type     rd_data;
  zsp_word_type     mem1 [2**AW];
  zsp_word_type     mem2 [2**AW];
  zsp_word_type     q1 [$];
  zsp_word_type     q2 [$];
  zsp_word_type     dp [2] = '{'0, '0};
  logic             op [2] = '{1'b0, 1'b0};
  logic             open = 1'b0;
  logic             dir = 1'b1;
  logic [AW-1:0]    base = '0;
  logic [1:0]       step = 2'h0;
  logic [2:0]       bad [3] = '{3'h5, 3'h3, 3'h0};
  logic [31:0]      seed = 32'h4316;
  logic [31:0]      seed_b = 32'h4316;
  int               err_count = 0;
  int               n_checks = 0;
  int               cyc = 0;

  zsp_if #(.ADDR_W(AW)) bus1 ();
  zsp_if #(.ADDR_W(AW)) bus2 ();

  zsp_sram_ctl #(.ADDR_W(AW)) u_zsp_sram_ctl (.clk(clk), .rst_b(rst_b),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
    .cmd_addr(cmd_addr), .cmd_lanes(cmd_lanes), .cmd_wdata(cmd_wdata),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
    .bus(bus1.ctl));
  zsp_sram_port #(.ADDR_W(AW)) u_zsp_sram_port (.clk(clk), .rst_b(rst_b),
    .bus(bus1.mem));
  // second port: this bench plays a controller that bursts and suspends
  zsp_sram_port #(.ADDR_W(AW)) u_zsp_sram_port2 (.clk(clk), .rst_b(rst_b),
    .bus(bus2.mem));
  zsp_sram_checker u_zsp_sram_checker (.clk(clk), .rst_b(rst_b),
    .read_not_write(bus1.read_not_write),
    .advance_or_load(bus1.advance_or_load),
    .select_low_a_n(bus1.select_low_a_n),
    .select_low_b_n(bus1.select_low_b_n), .select_high(bus1.select_high),
    .cycle_hold_n(bus1.cycle_hold_n), .sleep_request(bus1.sleep_request),
    .burst_order_sel(bus1.burst_order_sel), .ctl_dq_oe(bus1.ctl_dq_oe),
    .dev_dq_oe(bus1.dev_dq_oe));

  always #20 clk = ~clk;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  function automatic zsp_word_type rword();
    logic [63:0] t;
    seed = xs(seed);
    t[31:0] = seed;
    seed = xs(seed);
    t[63:32] = seed;
    return t[DATA_W-1:0];
  endfunction : rword

  function automatic zsp_word_type merge(input zsp_word_type o, n,
                                         input logic [LANES-1:0] en);
    for (int i = 0; i < LANES; i++)
      if (en[i])
        o[i*LANE_W +: LANE_W] = n[i*LANE_W +: LANE_W];
    return o;
  endfunction : merge

  task automatic check(input zsp_word_type seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  // one user command, held until the edge that takes it
  task automatic cmd(input logic w, input logic [AW-1:0] a,
                     input logic [LANES-1:0] l, input zsp_word_type d);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr = a;
    cmd_lanes = l;
    cmd_wdata = d;
    while (cmd_ready !== 1'b1)
      @(negedge clk);
    @(posedge clk);
    if (w)
      mem1[a] = merge(mem1[a], d, l);
    else
      q1.push_back(mem1[a]);
  endtask : cmd

  // one bus cycle on the second port; fr 0 live, 1 suspended, 2 asleep
  task automatic op2(input logic adv, rnw, input logic [2:0] sl,
                     input logic [AW-1:0] a, input logic [LANES-1:0] ln_n,
                     input zsp_word_type d, input int fr);
    logic [AW-1:0] ea;
    @(negedge clk);
    bus2.advance_or_load = adv;
    bus2.read_not_write = rnw;
    {bus2.select_low_a_n, bus2.select_low_b_n, bus2.select_high} = sl;
    bus2.addr = a;
    bus2.byte_lane_write_n = ln_n;
    bus2.cycle_hold_n = (fr == 1);
    bus2.sleep_request = (fr == 2);
    bus2.ctl_dq_out = dp[1];
    bus2.ctl_dq_oe = op[1];
    if (fr == 0)
    begin
      if (!adv)
      begin
        open = (sl == 3'h1);
        base = a;
        step = 2'h0;
        dir = rnw;
      end
      else if (open)
        step++;
      ea = {base[AW-1:2], bus2.burst_order_sel ? base[1:0] ^ step
                                               : base[1:0] + step};
      if (open && dir)
        q2.push_back(mem2[ea]);
      if (open && !dir && !rnw)
        mem2[ea] = merge(mem2[ea], d, ~ln_n);
      dp[1] = dp[0];
      op[1] = op[0];
      dp[0] = d;
      op[0] = open && !dir && !rnw;
    end
    @(posedge clk);
  endtask : op2

  // ------------------------------------------------------------
  // watchers: oldest note against each delivered word
  // ------------------------------------------------------------
  always @(negedge clk)
  begin
    seed_b = xs(seed_b);
    rd_ready = !stall && seed_b[3];
  end

  always @(posedge clk)
  begin
    if (rd_valid === 1'b1 && rd_ready === 1'b1)
      if (q1.size() == 0)
        check('1, '0);
      else
        check(rd_data, q1.pop_front());
    if (bus2.dev_dq_oe === 1'b1 && bus2.cycle_hold_n === 1'b0)
      if (q2.size() == 0)
        check('1, '0);
      else
        check(bus2.dq, q2.pop_front());
    cyc++;
    if (cyc == LIMIT)
    begin
      err_count++;
      final_report();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    {bus2.select_low_a_n, bus2.select_low_b_n, bus2.select_high} = 3'h5;
    bus2.advance_or_load = 1'b0;
    bus2.read_not_write = 1'b1;
    bus2.addr = '0;
    bus2.byte_lane_write_n = 4'hf;
    bus2.cycle_hold_n = 1'b0;
    bus2.sleep_request = 1'b0;
    bus2.output_en_n = 1'b0;
    bus2.burst_order_sel = 1'b1;
    bus2.ctl_dq_out = '0;
    bus2.ctl_dq_oe = 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    for (int i = 0; i < 2**AW; i++)
      cmd(1'b1, i[AW-1:0], 4'hf, rword());
    stall = 1'b0;
    for (int i = 0; i < 150; i++)
    begin
      seed = xs(seed);
      cmd(seed[0], seed[9:4], seed[13:10], rword());
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    wait (q1.size() == 0);
    // fifo fill: nothing drained, so the controller must refuse
    stall = 1'b1;
    for (int i = 0; i < DEPTH_FILL; i++)
      cmd(1'b0, i[AW-1:0], 4'h0, '0);
    @(negedge clk);
    cmd_valid = 1'b0;
    repeat (4) @(negedge clk);
    check(cmd_ready, '0);
    stall = 1'b0;
    wait (q1.size() == 0);
    for (int i = 0; i < 8; i++)
      op2(1'b0, 1'b0, 3'h1, i[AW-1:0], 4'h0, rword(), 0);
    op2(1'b0, 1'b0, 3'h1, 6, 4'ha, rword(), 0);
    op2(1'b1, 1'b0, 3'h1, 0, 4'h5, rword(), 0);
    op2(1'b1, 1'b0, 3'h1, 0, 4'h7, rword(), 0);
    op2(1'b1, 1'b0, 3'h1, 0, 4'he, rword(), 0);
    op2(1'b0, 1'b1, 3'h1, 5, 4'h0, '0, 0);
    op2(1'b1, 1'b1, 3'h1, 0, 4'h0, '0, 0);
    #5 bus2.output_en_n = 1'b1;
    #1 check(bus2.dev_dq_oe, '0);
    bus2.output_en_n = 1'b0;
    op2(1'b1, 1'b1, 3'h1, 0, 4'h0, '0, 1);
    op2(1'b1, 1'b1, 3'h1, 0, 4'h0, '0, 0);
    op2(1'b1, 1'b1, 3'h1, 0, 4'h0, '0, 2);
    op2(1'b1, 1'b1, 3'h1, 0, 4'h0, '0, 0);
    op2(1'b1, 1'b1, 3'h1, 0, 4'h0, '0, 0);
    for (int j = 0; j < 3; j++)
    begin
      op2(1'b0, 1'b1, 3'h1, 3, 4'h0, '0, 0);
      op2(1'b0, 1'b1, bad[j], 2, 4'h0, '0, 0);
      op2(1'b1, 1'b1, 3'h1, 0, 4'h0, '0, 0);
      #5 check(bus2.dev_dq_oe, '0);
    end
    op2(1'b0, 1'b0, 3'h1, 1, 4'h3, rword(), 0);
    for (int i = 0; i < 8; i++)
      op2(1'b0, 1'b1, 3'h1, i[AW-1:0], 4'h0, '0, 0);
    repeat (3) op2(1'b0, 1'b1, 3'h5, 0, 4'hf, '0, 0);
    check(q2.size(), '0);
    // second reset: order select moves only while the port is held
    @(negedge clk);
    rst_b = 1'b0;
    bus2.burst_order_sel = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    op2(1'b0, 1'b1, 3'h1, 1, 4'h0, '0, 0);
    repeat (4) op2(1'b1, 1'b1, 3'h1, 0, 4'h0, '0, 0);
    repeat (3) op2(1'b0, 1'b1, 3'h5, 0, 4'hf, '0, 0);
    check(q2.size(), '0);
    final_report();
  end

endmodule : pipelined_zero_turnaround_sram_port_tb_top
